// *** rtl/iss_pkg.sv ***
package iss_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ISS_STATUS_ADDR = 8'h11;
    localparam logic [7:0] ISS_CONTROL_ADDR = 8'h12;
    localparam logic [7:0] ISS_CONTROL_RESET = 8'h01;

    // ************************************************************
    // Status field positions
    // ************************************************************
    localparam int ISS_ST_HSYNC_ACT = 7;
    localparam int ISS_ST_GREEN_ACT = 6;
    localparam int ISS_ST_VSYNC_ACT = 5;
    localparam int ISS_ST_LINK_ACT = 4;
    localparam int ISS_ST_INTERFACE_CHOICE = 3;
    localparam int ISS_ST_HSYNC_CHOICE = 2;
    localparam int ISS_ST_VSYNC_CHOICE = 1;

    // ************************************************************
    // Control field positions
    // ************************************************************
    localparam int ISS_CT_INTERFACE_OVERRIDE = 7;
    localparam int ISS_CT_INTERFACE_PRIORITY = 6;
    localparam int ISS_CT_HSYNC_OVERRIDE = 5;
    localparam int ISS_CT_HSYNC_PRIORITY = 4;
    localparam int ISS_CT_VSYNC_OVERRIDE = 3;
    localparam int ISS_CT_VSYNC_SELECT = 2;
    localparam int ISS_CT_COAST_SELECT = 1;
    localparam int ISS_CT_POWER_ON = 0;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int ISS_CLK_PERIOD_NS = 40;
    localparam int ISS_ACT_WINDOW_NS = 100000;
    localparam int ISS_ACT_WINDOW_CYCLES =
        (ISS_ACT_WINDOW_NS / ISS_CLK_PERIOD_NS < 1) ? 1 :
        ISS_ACT_WINDOW_NS / ISS_CLK_PERIOD_NS;
    localparam int ISS_WINDOW_W = 12;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic hsync;
        logic greenEmbeddedSync;
        logic vsync;
        logic linkClock;
    } iss_sync_in_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic write;
        logic read;
    } iss_bus_req_t;

    typedef struct packed {
        logic interfaceChoice;
        logic hsyncChoice;
        logic vsyncChoice;
        logic seekMode;
        logic powerOn;
        logic hsyncSelected;
        logic vsyncSelected;
        logic coastSelected;
    } iss_sel_out_t;

    typedef struct packed {
        iss_sync_in_t prevIn;
        logic [3:0] seen;
        logic [3:0] activity;
        logic [ISS_WINDOW_W-1:0] windowCount;
        logic [7:0] control;
        logic [7:0] rdata;
        iss_sel_out_t sel;
    } iss_state_t;

endpackage : iss_pkg

// *** rtl/iss_source_select.sv ***
// What this block does
// R1 - Status bit 4 reports link clock activity.
// R2 - Analog seen if bits 7-5; digital bit 4.
// R3 - Auto interface choice from detectors, priority.
// R4 - Interface override forces choice to priority.
// R5 - Interface choice: 0 analog, 1 digital.
// R6 - Auto hsync choice from bits 7,6, priority.
// R7 - Hsync override forces choice to bit 4.
// R8 - Hsync choice: 0 pin, 1 green sync.
// R9 - Auto vsync choice equals vsync detect.
// R10 - Vsync override forces choice to bit 2.
// R11 - Vsync choice: 0 pin, 1 separator.
// R12 - Interface override resets to zero.
// R13 - Interface priority resets zero, 0 analog.
// R14 - Hsync override resets zero, automatic.
// R15 - Hsync priority resets zero, 0 pin.
// R16 - Vsync override resets zero, automatic.
// R17 - Vsync select resets zero, 0 pin.
// R18 - Coast select: 0 coast pin, 1 vsync.
// R19 - Status bits 7,6,5 report sync activity.
// R20 - Constant level not reported active, except one held high out of reset.
// R21 - Selections re-evaluated every cycle.
module iss_source_select
    import iss_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = ISS_ACT_WINDOW_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire iss_sync_in_t syncIn,
    input wire logic sepVsyncIn,
    input wire logic coastIn,
    input wire iss_bus_req_t busReq,
    output iss_bus_req_t unusedReq,
    output logic [7:0] readData,
    output iss_sel_out_t selOut
);

    iss_state_t s;
    iss_state_t next_s;

    logic [3:0] edges;
    logic analogDetect;
    logic digitalDetect;
    logic ifOvr;
    logic ifPri;
    logic hsOvr;
    logic hsPri;
    logic vsOvr;
    logic vsSel;
    logic vsyncNow;

    assign unusedReq = '0;

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb
    begin
        next_s = s;
        next_s.rdata = 8'h00;
        // A level held low gives no edge; one held high gives one edge after reset, as prevIn resets to 0.
        edges = 4'(syncIn ^ s.prevIn); // R20
        next_s.prevIn = syncIn;

        // Edges seen in the closing cycle count for the next window
        // too, so an event at the boundary is never lost.
        if (s.windowCount == ISS_WINDOW_W'(WINDOW_CYCLES - 1))
        begin
            next_s.windowCount = '0;
            next_s.activity = s.seen | edges; // R1 R19
            next_s.seen = edges;
        end
        else
        begin
            next_s.windowCount = s.windowCount + ISS_WINDOW_W'(1);
            next_s.seen = s.seen | edges;
        end

        ifOvr = s.control[ISS_CT_INTERFACE_OVERRIDE];
        ifPri = s.control[ISS_CT_INTERFACE_PRIORITY];
        hsOvr = s.control[ISS_CT_HSYNC_OVERRIDE];
        hsPri = s.control[ISS_CT_HSYNC_PRIORITY];
        vsOvr = s.control[ISS_CT_VSYNC_OVERRIDE];
        vsSel = s.control[ISS_CT_VSYNC_SELECT];

        analogDetect = |s.activity[3:1]; // R2
        digitalDetect = s.activity[0]; // R2

        // Choices follow detectors and control every cycle.
        next_s.sel.seekMode = 1'b0; // R21
        if (ifOvr)
        begin
            next_s.sel.interfaceChoice = ifPri; // R4 R12
        end
        else if (analogDetect && digitalDetect)
        begin
            next_s.sel.interfaceChoice = ifPri; // R3 R13
        end
        else if (digitalDetect)
        begin
            next_s.sel.interfaceChoice = 1'b1; // R3 R5
        end
        else if (analogDetect)
        begin
            next_s.sel.interfaceChoice = 1'b0; // R3 R5
        end
        else
        begin
            // Seek mode keeps the last choice rather than flapping.
            next_s.sel.seekMode = 1'b1; // R3
        end

        if (hsOvr || (s.activity[3] == s.activity[2]))
        begin
            next_s.sel.hsyncChoice = hsPri; // R6 R7 R14 R15
        end
        else
        begin
            next_s.sel.hsyncChoice = s.activity[2]; // R6 R8
        end

        if (vsOvr)
        begin
            next_s.sel.vsyncChoice = vsSel; // R10 R16 R17
        end
        else
        begin
            next_s.sel.vsyncChoice = s.activity[1]; // R9
        end

        next_s.sel.hsyncSelected = s.sel.hsyncChoice ?
            syncIn.greenEmbeddedSync : syncIn.hsync; // R8
        vsyncNow = s.sel.vsyncChoice ? sepVsyncIn : syncIn.vsync; // R11
        next_s.sel.vsyncSelected = vsyncNow;
        next_s.sel.coastSelected = s.control[ISS_CT_COAST_SELECT] ?
            vsyncNow : coastIn; // R18
        next_s.sel.powerOn = s.control[ISS_CT_POWER_ON];

        // ********************************************************
        // Register port
        // ********************************************************
        if (busReq.write && busReq.addr == ISS_CONTROL_ADDR)
        begin
            next_s.control = busReq.wdata;
        end
        if (busReq.read)
        begin
            unique case (busReq.addr)
                ISS_STATUS_ADDR:
                begin
                    next_s.rdata = {s.activity,
                        s.sel.interfaceChoice, s.sel.hsyncChoice,
                        s.sel.vsyncChoice, 1'b0}; // R21
                end
                ISS_CONTROL_ADDR:
                begin
                    next_s.rdata = s.control;
                end
                default:
                begin
                    next_s.rdata = 8'h00;
                end
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
        begin
            s <= '0;
            s.control <= ISS_CONTROL_RESET; // R12 R13 R14 R15 R16 R17
            s.sel.powerOn <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign readData = s.rdata;
    assign selOut = s.sel;

endmodule : iss_source_select

// *** verif/iss_sync_source.sv ***
module iss_sync_source
    import iss_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] actMask,
    input wire logic [3:0] idleLevel,
    output iss_sync_in_t syncIn,
    output logic sepVsyncIn,
    output logic coastIn
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] lvl = 4'h0;
    logic [3:0] phase = 4'h0;
    assign syncIn = lvl;
    assign sepVsyncIn = phase[1];
    assign coastIn = phase[2];
    // Lines that are not active sit at a fixed level, high or low.
    always @(posedge sys_clk)
    begin
        phase <= phase + 4'h1;
        lvl <= (actMask & ~lvl) | (~actMask & idleLevel);
    end
endmodule : iss_sync_source

// *** verif/iss_source_select_asserts.sv ***
module iss_source_select_asserts
    import iss_pkg::*;
#(
    parameter int unsigned WINDOW_CYCLES = ISS_ACT_WINDOW_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset,
    input wire iss_sync_in_t syncIn,
    input wire logic sepVsyncIn,
    input wire logic coastIn,
    input wire iss_bus_req_t busReq,
    input wire iss_bus_req_t unusedReq,
    input wire logic [7:0] readData,
    input wire iss_sel_out_t selOut
);
    logic [7:0] ctl;
    logic hsMux;
    logic vsMux;
    logic coastMux;
    assign hsMux = selOut.hsyncChoice ? syncIn.greenEmbeddedSync : syncIn.hsync;
    assign vsMux = selOut.vsyncChoice ? sepVsyncIn : syncIn.vsync;
    assign coastMux = ctl[1] ? vsMux : coastIn;
    // Control mirror built from bus writes, so no internal probe is needed.
    always_ff @(posedge sys_clk or posedge reset)
    begin
        if (reset)
            ctl <= ISS_CONTROL_RESET;
        else if (busReq.write && busReq.addr == ISS_CONTROL_ADDR)
            ctl <= busReq.wdata;
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    chk_iface_ovr: assert property (ctl[7] |=>
        selOut.interfaceChoice == $past(ctl[6])) else $error("iface ovr");
    chk_hs_ovr: assert property (ctl[5] |=>
        selOut.hsyncChoice == $past(ctl[4])) else $error("hsync ovr");
    chk_vs_ovr: assert property (ctl[3] |=>
        selOut.vsyncChoice == $past(ctl[2])) else $error("vsync ovr");
    chk_read_ctl: assert property (busReq.read &&
        busReq.addr == ISS_CONTROL_ADDR ##1 1'b1 |-> readData == $past(ctl))
        else $error("control read");
    chk_read_zero: assert property ((!busReq.read ||
        busReq.addr > ISS_CONTROL_ADDR || busReq.addr < ISS_STATUS_ADDR)
        |=> readData == 8'h00) else $error("read not zero");
    chk_hs_sel: assert property (!$past(reset) |->
        selOut.hsyncSelected == $past(hsMux)) else $error("hsync mux");
    chk_vs_sel: assert property (!$past(reset) |->
        selOut.vsyncSelected == $past(vsMux)) else $error("vsync mux");
    chk_coast_sel: assert property (!$past(reset) |->
        selOut.coastSelected == $past(coastMux)) else $error("coast mux");
    chk_power_bit: assert property (!$past(reset) |->
        selOut.powerOn == $past(ctl[0])) else $error("power bit");
    cover property (ctl[7] && selOut.interfaceChoice);
    cover property (selOut.seekMode);
    cover property (busReq.read ##1 readData != 8'h00);
endmodule : iss_source_select_asserts
bind iss_source_select iss_source_select_asserts #(
    .WINDOW_CYCLES(WINDOW_CYCLES)) chk (.sys_clk, .reset, .syncIn,
    .sepVsyncIn, .coastIn, .busReq, .unusedReq, .readData, .selOut);

// *** verif/tb.sv ***
module tb
    import iss_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    iss_sync_in_t syncIn;
    logic sepVsyncIn;
    logic coastIn;
    iss_bus_req_t busReq = '0;
    logic [7:0] readData;
    iss_sel_out_t selOut;
    logic [3:0] actMask = 4'h0;
    logic [3:0] idleLevel = 4'hA;
    logic [3:0] m;
    logic [7:0] nc;
    logic [7:0] rd;
    logic held = 1'b0;
    int bad_count = 0;
    int tests_run = 0;
    always #20 sys_clk = ~sys_clk;
    iss_sync_source src (.sys_clk, .actMask, .idleLevel, .syncIn,
        .sepVsyncIn, .coastIn);
    iss_source_select #(.WINDOW_CYCLES(8)) dut (.sys_clk, .reset, .syncIn,
        .sepVsyncIn, .coastIn, .busReq, .unusedReq(), .readData, .selOut);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        busReq <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        busReq <= '0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge sys_clk);
        busReq <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge sys_clk);
        busReq <= '0;
        #1 rd = readData;
    endtask : rdr
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    // Interface choice keeps its last value while no interface is seen.
    function automatic logic [7:0] expStatus(input logic [3:0] a,
        input logic [7:0] c, inout logic h);
        if (c[7] || (|a[3:1] && a[0]))
            h = c[6];
        else if (|a)
            h = a[0];
        return {a, h, c[5] ? c[4] : ((a[3] ^ a[2]) ? a[2] : c[4]),
            c[3] ? c[2] : a[1], 1'b0};
    endfunction : expStatus
    initial
    begin
        void'($urandom(67));
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (24) @(posedge sys_clk);
        rdr(ISS_CONTROL_ADDR);
        cmp(rd, ISS_CONTROL_RESET);
        rdr(ISS_STATUS_ADDR);
        cmp(rd, 8'h00);
        wr(ISS_STATUS_ADDR, 8'hFF);
        rdr(8'h13);
        cmp(rd, 8'h00);
        rdr(ISS_CONTROL_ADDR);
        cmp(rd, ISS_CONTROL_RESET);
        for (int i = 0; i < 48; i++)
        begin
            m = (i < 16) ? i[3:0] : 4'($urandom);
            nc = 8'($urandom);
            wr(ISS_CONTROL_ADDR, nc);
            repeat (2) @(posedge sys_clk);
            void'(expStatus(actMask, nc, held));
            actMask <= m;
            repeat (24) @(posedge sys_clk);
            rdr(ISS_STATUS_ADDR);
            cmp(rd, expStatus(m, nc, held));
            rdr(ISS_CONTROL_ADDR);
            cmp(rd, nc);
        end
        summarize();
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
endmodule : tb
